// >>> fps_pkg.sv
package fps_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SW_PERIOD_NS = 10000;
    localparam int SW_PERIOD_CYC = SW_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MAX_DUTY_PCT = 80;
    localparam int MAX_ON_CYC = (SW_PERIOD_CYC * MAX_DUTY_PCT) / 100;
    localparam int DISCH_NS = 500;
    localparam int DISCH_CYC = DISCH_NS / CLK_PERIOD_NS;
    localparam int LEB_NS = 250;
    localparam int LEB_CYC = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_BLANK = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_EVENT = 12'h00C;
    localparam logic [11:0] ADDR_PULSES = 12'h010;

    localparam int BLANK_W = 8;
    localparam logic [7:0] BLANK_RST = 8'(LEB_CYC);
    localparam int PULSE_CNT_W = 16;

    localparam int CTRL_INHIBIT_BIT = 0;

    localparam int ST_PHASE_LSB = 0;
    localparam int ST_GATE_BIT = 2;
    localparam int ST_DEMAG_BIT = 3;
    localparam int ST_OUTCOME_BIT = 4;
    localparam int ST_MODE_BIT = 5;
    localparam int ST_OVP_BIT = 6;
    localparam int ST_STBY_BIT = 7;
    localparam int ST_SELF_OSC_BIT = 8;

    localparam int EV_OC_BIT = 0;
    localparam int EV_REG_BIT = 1;
    localparam int EV_OVP_BIT = 2;
    localparam int EV_UVLO_BIT = 3;
    localparam int EV_RESTART_BIT = 4;
    localparam int EV_MODE_SET_BIT = 5;
    localparam int EV_MODE_CLR_BIT = 6;
    localparam int EV_W = 7;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {PH_START_UP, PH_SWITCHING, PH_LATCHED_OFF} fps_phase_t;

    typedef struct packed {
        logic vccOverVolt;
        logic vccStartReached;
        logic vccBelowWork;
        logic vccBelowRestart;
        logic senseOverCurrent;
        logic regulationCompareSignal;
        logic windingBelowRef;
        logic fastOvervoltageTrip;
        logic modeDirectClear;
        logic windingGrounded;
    } fps_cmp_t;

    typedef struct packed {
        logic gateDrive;
        logic hvStartEn;
        logic senseSourceEn;
        logic standby;
    } fps_drv_t;

endpackage

// >>> fps_pwm_sequencer.sv
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
// Operation
// - Cycle start sets latch; regulation or overcurrent clears
// - At most one gate pulse per cycle
// - Sense threshold flags overcurrent, ends on-time
// - Blank sense comparator after each turn-on
// - Stand-by enables sense current source
// - Demag latch holds until next pulse
// - Gate disabled while demagnetization runs
// - Fast overvoltage latches gate off
// - Grounded winding input disables demag, fast OVP
// - Oscillator waits at valley for demag done
// - Overvoltage keeps gate off until start-up
// - Start-up source on until start threshold
// - Pulse end stores outcome: one without overcurrent
// - Low working threshold ends switching, latches off
// - Restart threshold ends latched-off, restarts start-up
// - Start-up after overload clears mode latch
// - Clear mode latch means normal mode
// - On-time limited to maximum duty cycle
// - Overload keeps outcome latch at zero
// - Outcome one sets mode latch when latched-off
// - Low winding current clears mode latch directly
// - Set mode latch gives stand-by switching
module fps_pwm_sequencer
    import fps_pkg::*;
#(
    parameter int PERIOD_CYC = SW_PERIOD_CYC,
    parameter int MAX_ON = MAX_ON_CYC,
    parameter int DISCH = DISCH_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fps_cmp_t cmpIn,
    output fps_drv_t drvOut
);

    localparam int CNT_W = $clog2(PERIOD_CYC + 1);
    localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(PERIOD_CYC - 1);
    localparam logic [CNT_W-1:0] MAX_ON_CNT = CNT_W'(MAX_ON);
    localparam logic [CNT_W-1:0] DISCH_START = CNT_W'(PERIOD_CYC - DISCH);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    fps_cmp_t cmpMeta_r;
    fps_cmp_t cmp_r;
    fps_phase_t phase_r;
    logic [CNT_W-1:0] ramp_r;
    logic [BLANK_W-1:0] blankCnt_r;
    logic pulse_r;
    logic magnetResetDone_r;
    logic [1:0] gateHist_r;
    logic cycleOutcome_r;
    logic mode_r;
    logic ovp_r;
    logic standby_r;
    logic hvStartEn_r;
    logic inhibit_r;
    logic [BLANK_W-1:0] blank_r;
    logic [EV_W-1:0] event_r;
    logic [PULSE_CNT_W-1:0] pulses_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    logic demagOk;
    logic fastOvEff;
    logic selfOsc;
    logic cycleStart;
    logic pulseSet;
    logic blankDone;
    logic overcurrentFlag;
    logic regTrip;
    logic dutyLimit;
    logic pulseClr;
    logic enterSwitch;
    logic enterLatched;
    logic enterStart;
    logic modeSet;
    logic modeClr;
    logic ovpSet;
    logic [EV_W-1:0] eventSet;
    logic accessPend;
    logic wrEn;
    logic hit;
    logic [31:0] rdValue;
    logic [31:0] statusWord;

    ////////////////////////////////////////////////////////////////////////
    // Comparator synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmpMeta_r <= '0;
            cmp_r <= '0;
        end else if (clkEn) begin
            cmpMeta_r <= cmpIn;
            cmp_r <= cmpMeta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Derived conditions
    assign demagOk = magnetResetDone_r || cmp_r.windingGrounded;
    assign fastOvEff = cmp_r.fastOvervoltageTrip && !cmp_r.windingGrounded;
    assign selfOsc = (ramp_r == '0) && !demagOk;
    assign cycleStart = (ramp_r == '0) && demagOk;
    assign pulseSet = cycleStart && (phase_r == PH_SWITCHING) && !ovp_r && !inhibit_r
        && !ovpSet;
    assign blankDone = (blankCnt_r >= blank_r);
    assign overcurrentFlag = pulse_r && blankDone && cmp_r.senseOverCurrent;
    assign regTrip = pulse_r && cmp_r.regulationCompareSignal;
    assign dutyLimit = pulse_r && (ramp_r >= MAX_ON_CNT);
    assign pulseClr = regTrip || overcurrentFlag || dutyLimit;

    assign enterSwitch = (phase_r == PH_START_UP) && cmp_r.vccStartReached;
    assign enterLatched = (phase_r == PH_SWITCHING) && cmp_r.vccBelowWork;
    assign enterStart = (phase_r == PH_LATCHED_OFF) && cmp_r.vccBelowRestart;
    assign modeSet = enterLatched && cycleOutcome_r;
    assign modeClr = (enterStart && !cycleOutcome_r) || cmp_r.modeDirectClear;
    assign ovpSet = cmp_r.vccOverVolt || fastOvEff;

    ////////////////////////////////////////////////////////////////////////
    // Oscillator ramp: holds at valley until demagnetization is done
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_r <= '0;
        end else if (clkEn) begin
            if (ramp_r == LAST_CNT) begin
                ramp_r <= '0;
            end else if (ramp_r != '0 || demagOk) begin
                ramp_r <= ramp_r + CNT_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= PH_START_UP;
        end else if (clkEn) begin
            unique case (phase_r)
                PH_START_UP: begin
                    if (enterSwitch) begin
                        phase_r <= PH_SWITCHING;
                    end
                end
                PH_SWITCHING: begin
                    if (enterLatched) begin
                        phase_r <= PH_LATCHED_OFF;
                    end
                end
                PH_LATCHED_OFF: begin
                    if (enterStart) begin
                        phase_r <= PH_START_UP;
                    end
                end
                default: begin
                    phase_r <= PH_START_UP;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse latch; set only at cycle start, so one pulse per cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_r <= 1'b0;
        end else if (clkEn) begin
            if (pulse_r && (pulseClr || ovpSet || enterLatched || phase_r != PH_SWITCHING)) begin
                pulse_r <= 1'b0;
            end else if (pulseSet) begin
                pulse_r <= 1'b1;
            end
        end
    end

    // Leading edge blanking counter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blankCnt_r <= '0;
        end else if (clkEn) begin
            if (pulseSet) begin
                blankCnt_r <= '0;
            end else if (pulse_r && !blankDone) begin
                blankCnt_r <= blankCnt_r + BLANK_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate history: synced winding samples lag the gate by two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gateHist_r <= '0;
        end else if (clkEn) begin
            gateHist_r <= {gateHist_r[0], pulse_r};
        end
    end

    // Demagnetization latch, armed only once synced samples show off-time
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            magnetResetDone_r <= 1'b0;
        end else if (clkEn) begin
            if (pulseSet) begin
                magnetResetDone_r <= 1'b0;
            end else if (!pulse_r && gateHist_r == '0 && cmp_r.windingBelowRef) begin
                magnetResetDone_r <= 1'b1;
            end
        end
    end

    // Cycle outcome: an overcurrent at pulse end wins over regulation
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cycleOutcome_r <= 1'b0;
        end else if (clkEn) begin
            if (pulse_r && pulseClr) begin
                cycleOutcome_r <= !overcurrentFlag;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode latch, set wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= 1'b0;
        end else if (clkEn) begin
            if (modeSet) begin
                mode_r <= 1'b1;
            end else if (modeClr) begin
                mode_r <= 1'b0;
            end
        end
    end

    // Overvoltage latch, cleared only by a new start-up
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovp_r <= 1'b0;
        end else if (clkEn) begin
            if (ovpSet) begin
                ovp_r <= 1'b1;
            end else if (enterStart) begin
                ovp_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            standby_r <= 1'b0;
            hvStartEn_r <= 1'b1;
        end else if (clkEn) begin
            standby_r <= (phase_r == PH_SWITCHING) && mode_r;
            hvStartEn_r <= (phase_r == PH_START_UP) && !enterSwitch;
        end
    end

    assign drvOut.gateDrive = pulse_r;
    assign drvOut.hvStartEn = hvStartEn_r;
    assign drvOut.senseSourceEn = standby_r;
    assign drvOut.standby = standby_r;

    ////////////////////////////////////////////////////////////////////////
    // Sticky events and pulse counter
    always_comb begin
        eventSet = '0;
        eventSet[EV_OC_BIT] = overcurrentFlag;
        eventSet[EV_REG_BIT] = regTrip;
        eventSet[EV_OVP_BIT] = ovpSet;
        eventSet[EV_UVLO_BIT] = enterLatched;
        eventSet[EV_RESTART_BIT] = enterStart;
        eventSet[EV_MODE_SET_BIT] = modeSet;
        eventSet[EV_MODE_CLR_BIT] = modeClr && !modeSet;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_r <= '0;
        end else if (clkEn) begin
            if (wrEn && paddr == ADDR_EVENT && pstrb[0]) begin
                event_r <= eventSet | (event_r & ~pwdata[EV_W-1:0]);
            end else begin
                event_r <= event_r | eventSet;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulses_r <= '0;
        end else if (clkEn) begin
            if (wrEn && paddr == ADDR_PULSES) begin
                pulses_r <= pulseSet ? PULSE_CNT_W'(1) : '0;
            end else if (pulseSet) begin
                pulses_r <= pulses_r + PULSE_CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            inhibit_r <= 1'b0;
            blank_r <= BLANK_RST;
        end else if (clkEn && wrEn && pstrb[0]) begin
            if (paddr == ADDR_CTRL) begin
                inhibit_r <= pwdata[CTRL_INHIBIT_BIT];
            end
            if (paddr == ADDR_BLANK) begin
                blank_r <= pwdata[BLANK_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, read data sampled in the first access cycle, write data taken in the ready cycle
    assign accessPend = psel && penable && !pready_r;
    assign wrEn = psel && penable && pready_r && pwrite;

    always_comb begin
        statusWord = '0;
        statusWord[ST_PHASE_LSB +: 2] = phase_r;
        statusWord[ST_GATE_BIT] = pulse_r;
        statusWord[ST_DEMAG_BIT] = magnetResetDone_r;
        statusWord[ST_OUTCOME_BIT] = cycleOutcome_r;
        statusWord[ST_MODE_BIT] = mode_r;
        statusWord[ST_OVP_BIT] = ovp_r;
        statusWord[ST_STBY_BIT] = standby_r;
        statusWord[ST_SELF_OSC_BIT] = selfOsc;
    end

    always_comb begin
        hit = 1'b1;
        rdValue = '0;
        unique case (paddr)
            ADDR_CTRL: rdValue[CTRL_INHIBIT_BIT] = inhibit_r;
            ADDR_BLANK: rdValue[BLANK_W-1:0] = blank_r;
            ADDR_STATUS: rdValue = statusWord;
            ADDR_EVENT: rdValue[EV_W-1:0] = event_r;
            ADDR_PULSES: rdValue[PULSE_CNT_W-1:0] = pulses_r;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else if (clkEn) begin
            pready_r <= accessPend;
            pslverr_r <= accessPend && !hit;
            if (accessPend) begin
                prdata_r <= (pwrite || !hit) ? 32'h0000_0000 : rdValue;
            end
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;

endmodule

// >>> fps_pwm_sequencer_properties.sv
`timescale 1ns/10ps
module fps_pwm_sequencer_properties
    import fps_pkg::*;
#(
    parameter int PERIOD_CYC = SW_PERIOD_CYC,
    parameter int MAX_ON = MAX_ON_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire fps_cmp_t cmpIn,
    input wire fps_drv_t drvOut
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic gateDly_r;
    int onCnt_r;
    int rise_r;
    // Gate high length and rise-to-rise distance
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gateDly_r <= 1'b0;
            onCnt_r <= 0;
            rise_r <= 999;
        end else begin
            gateDly_r <= drvOut.gateDrive;
            onCnt_r <= drvOut.gateDrive ? onCnt_r + 1 : 0;
            if (drvOut.gateDrive && !gateDly_r) begin
                rise_r <= 1;
            end else if (rise_r < 999) begin
                rise_r <= rise_r + 1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_fast_overvoltage_trip;
        (cmpIn.fastOvervoltageTrip && !cmpIn.windingGrounded) [*4];
    endsequence
    sequence s_reg;
        (drvOut.gateDrive && cmpIn.regulationCompareSignal) [*3];
    endsequence
    property p_fast_overvoltage_trip; s_fast_overvoltage_trip |=> !drvOut.gateDrive; endproperty
    property p_reg; s_reg |=> !drvOut.gateDrive; endproperty
    property p_vovp; cmpIn.vccOverVolt [*4] |=> !drvOut.gateDrive; endproperty
    property p_uvlo; cmpIn.vccBelowWork [*4] |=> !drvOut.gateDrive; endproperty
    property p_rest; cmpIn.vccBelowRestart [*6] |=> drvOut.hvStartEn; endproperty
    property p_start;
        (cmpIn.vccStartReached && !cmpIn.vccBelowWork) [*4] |=> !drvOut.hvStartEn;
    endproperty
    property p_hv; drvOut.gateDrive |-> !drvOut.hvStartEn; endproperty
    property p_one; $rose(drvOut.gateDrive) |-> rise_r >= PERIOD_CYC; endproperty
    property p_max; drvOut.gateDrive |-> onCnt_r <= MAX_ON; endproperty
    property p_stby; cmpIn.modeDirectClear [*4] |=> !drvOut.senseSourceEn; endproperty
    a_fast_overvoltage_trip: assert property (p_fast_overvoltage_trip) else $error("gate after fast ovp");
    a_reg: assert property (p_reg) else $error("gate kept after regulation");
    a_vovp: assert property (p_vovp) else $error("gate after vcc ovp");
    a_uvlo: assert property (p_uvlo) else $error("gate below work level");
    a_rest: assert property (p_rest) else $error("no restart");
    a_start: assert property (p_start) else $error("source kept on");
    a_hv: assert property (p_hv) else $error("gate during start-up");
    a_one: assert property (p_one) else $error("second pulse in cycle");
    a_max: assert property (p_max) else $error("on-time too long");
    a_stby: assert property (p_stby) else $error("source kept after direct clear");
endmodule
bind fps_pwm_sequencer fps_pwm_sequencer_properties #(.PERIOD_CYC(PERIOD_CYC),
    .MAX_ON(MAX_ON)) i_props (.core_clk(core_clk), .rst_n(rst_n), .cmpIn(cmpIn),
    .drvOut(drvOut));

// >>> fps_analog_model.sv
`timescale 1ns/10ps
module fps_analog_model
    import fps_pkg::*;
(
    input wire logic core_clk,
    input wire fps_drv_t drvOut,
    input wire logic [15:0] vccMv,
    input wire logic [7:0] regAt,
    input wire logic [7:0] ocAt,
    input wire logic [7:0] demagAt,
    input wire logic fast_overvoltage_trip,
    input wire logic grounded,
    input wire logic dirClr,
    output fps_cmp_t cmpIn
);
    logic [7:0] onCnt = 8'h00;
    logic [7:0] offCnt = 8'h00;
    always @(posedge core_clk) begin
        onCnt <= drvOut.gateDrive ? onCnt + 8'h01 : 8'h00;
        offCnt <= drvOut.gateDrive ? 8'h00 : offCnt + 8'(offCnt != 8'hFF);
    end
    // Winding rings around the reference once demagnetized
    always_comb begin
        cmpIn.vccOverVolt = vccMv > 16'h3C28;
        cmpIn.vccStartReached = vccMv >= 16'h32C8;
        cmpIn.vccBelowWork = vccMv < 16'h2710;
        cmpIn.vccBelowRestart = vccMv <= 16'h1964;
        cmpIn.senseOverCurrent = drvOut.gateDrive && ocAt != 8'h00 && onCnt >= ocAt;
        cmpIn.regulationCompareSignal = drvOut.gateDrive && regAt != 8'h00 && onCnt >= regAt;
        cmpIn.windingBelowRef = grounded || drvOut.gateDrive || (offCnt >= demagAt && !offCnt[1]);
        cmpIn.fastOvervoltageTrip = fast_overvoltage_trip;
        cmpIn.modeDirectClear = dirClr;
        cmpIn.windingGrounded = grounded;
    end
endmodule

// >>> fps_pwm_sequencer_tb.sv
`timescale 1ns/10ps
module fps_pwm_sequencer_tb
    import fps_pkg::*;
;
    localparam int PER = 20;
    localparam int MON = 16;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fps_cmp_t cmpIn;
    fps_drv_t drvOut;
    logic [15:0] vcc = 16'h1388;
    logic [7:0] regAt = 8'h00;
    logic [7:0] ocAt = 8'h00;
    logic [7:0] demagAt = 8'h03;
    logic fast_overvoltage_trip = 1'b0;
    logic gnd = 1'b0;
    logic dirClr = 1'b0;
    logic gPrev = 1'b0;
    int fails = 0;
    int checks_done = 0;
    int pulses = 0;
    int width = 0;
    int period = 0;
    int onNow = 0;
    int since = 0;
    int p0 = 0;
    always #2.5 core_clk = ~core_clk;
    fps_pwm_sequencer #(.PERIOD_CYC(PER), .MAX_ON(MON), .DISCH(2)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmpIn(cmpIn), .drvOut(drvOut));
    fps_analog_model i_model (.core_clk(core_clk), .drvOut(drvOut), .vccMv(vcc),
        .regAt(regAt), .ocAt(ocAt), .demagAt(demagAt), .fast_overvoltage_trip(fast_overvoltage_trip), .grounded(gnd),
        .dirClr(dirClr), .cmpIn(cmpIn));
    ////////////////////////////////////////////////////////////////////////
    // Pulse count, width and period seen on the gate
    always @(posedge core_clk) begin
        gPrev <= drvOut.gateDrive;
        since <= since + 1;
        if (drvOut.gateDrive === 1'b1 && gPrev !== 1'b1) begin
            pulses <= pulses + 1;
            period <= since;
            since <= 1;
            onNow <= 1;
        end else if (drvOut.gateDrive === 1'b1) begin
            onNow <= onNow + 1;
        end else if (gPrev === 1'b1) begin
            width <= onNow;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        input logic [31:0] mask, input logic [31:0] exp);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        chk("pslverr", 32'(a > ADDR_PULSES), 32'(pslverr));
        if (!wr) chk("prdata", exp, prdata & mask);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic vset(input logic [15:0] v, input int n);
        vcc <= v;
        run(n);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        run(20000);
        fails++;
        test_done();
    end
    initial begin
        void'($urandom(99));
        run(2);
        rst_n <= 1'b1;
        chk("drvOut", 32'h4, 32'(drvOut));
        apb(1'b0, ADDR_STATUS, 0, 32'h67, 32'h0);
        apb(1'b0, ADDR_BLANK, 0, 32'hFF, 32'h32);
        apb(1'b0, 12'h020, 0, 32'hFFFFFFFF, 32'h0);
        apb(1'b1, ADDR_BLANK, 32'h8, 0, 0);
        vset(16'h36B0, 20);
        chk("hvStartEn", 0, 32'(drvOut.hvStartEn));
        apb(1'b0, ADDR_STATUS, 0, 32'h3, 32'h1);
        $display("test start-up done");
        regAt <= 8'(5 + $urandom % 6);
        apb(1'b1, ADDR_CTRL, 32'h1, 0, 0);
        run(40);
        apb(1'b1, ADDR_PULSES, 32'h0, 0, 0);
        p0 = pulses;
        apb(1'b1, ADDR_CTRL, 32'h0, 0, 0);
        run(200);
        apb(1'b1, ADDR_CTRL, 32'h1, 0, 0);
        run(40);
        apb(1'b0, ADDR_PULSES, 0, 32'hFFFF, 32'(pulses - p0));
        chk("width", 1, 32'(width > regAt && width <= regAt + 5));
        apb(1'b0, ADDR_STATUS, 0, 32'h10, 32'h10);
        apb(1'b1, ADDR_CTRL, 32'h0, 0, 0);
        regAt <= 8'h00;
        run(100);
        chk("width", 1, 32'(width >= MON - 1 && width <= MON + 1));
        ocAt <= 8'h01;
        regAt <= 8'h0E;
        run(100);
        chk("width", 1, 32'(width >= 8 && width <= 12));
        apb(1'b0, ADDR_STATUS, 0, 32'h10, 32'h0);
        apb(1'b0, ADDR_EVENT, 0, 32'h1, 32'h1);
        $display("test pulse done");
        ocAt <= 8'h00;
        regAt <= 8'h05;
        demagAt <= 8'h1E;
        run(200);
        chk("period", 1, 32'(period > 35));
        gnd <= 1'b1;
        run(100);
        chk("period", PER, 32'(period));
        demagAt <= 8'h03;
        fast_overvoltage_trip <= 1'b1;
        p0 = pulses;
        run(60);
        chk("pulses", 1, 32'(pulses > p0));
        gnd <= 1'b0;
        run(60);
        p0 = pulses;
        run(60);
        fast_overvoltage_trip <= 1'b0;
        vset(16'h3E80, 20);
        vset(16'h36B0, 60);
        chk("pulses", p0, 32'(pulses));
        apb(1'b0, ADDR_STATUS, 0, 32'h40, 32'h40);
        vset(16'h2328, 20);
        apb(1'b0, ADDR_STATUS, 0, 32'h23, 32'h22);
        vset(16'h1770, 20);
        chk("hvStartEn", 1, 32'(drvOut.hvStartEn));
        vset(16'h36B0, 60);
        chk("pulses", 1, 32'(pulses > p0));
        chk("standby", 32'h3, 32'(drvOut) & 32'h3);
        $display("test protection done");
        ocAt <= 8'h01;
        regAt <= 8'h00;
        vset(16'h36B0, 60);
        vset(16'h2328, 20);
        vset(16'h1770, 20);
        apb(1'b0, ADDR_STATUS, 0, 32'h30, 32'h0);
        vset(16'h36B0, 60);
        chk("standby", 0, 32'(drvOut) & 32'h3);
        ocAt <= 8'h00;
        regAt <= 8'h05;
        vset(16'h36B0, 60);
        vset(16'h2328, 20);
        vset(16'h1770, 20);
        vset(16'h36B0, 60);
        chk("standby", 32'h3, 32'(drvOut) & 32'h3);
        dirClr <= 1'b1;
        run(10);
        chk("standby", 0, 32'(drvOut) & 32'h3);
        dirClr <= 1'b0;
        $display("test mode done");
        test_done();
    end
endmodule
